// >>> verilog/ppcd_params.svh
`ifndef PPCD_PARAMS_SVH
`define PPCD_PARAMS_SVH

// register indices; byte address is four times the index
`define PPCD_IDX_PAR_CTRL 6'h02
`define PPCD_IDX_PC_DATA 6'h03
`define PPCD_IDX_PC_DIR 6'h07
`define PPCD_IDX_PD_DATA 6'h08
`define PPCD_IDX_PD_DIR 6'h09
`define PPCD_IDX_PA_CTRL 6'h26

// reset values
`define PPCD_RST_PAR_CTRL 8'h00
`define PPCD_RST_PC_DATA 8'h00
`define PPCD_RST_PC_DIR 8'h00
`define PPCD_RST_PD_DATA 8'h00
`define PPCD_RST_PD_DIR 8'h00
`define PPCD_RST_PA_CTRL 8'h00

// field positions
`define PPCD_PARALLEL_IO_CONTROL_OPEN_DRAIN 5
`define PPCD_PULSE_ACCUM_CONTROL_PA3_DIR 3
`define PPCD_PULSE_ACCUM_CONTROL_CAP4_SEL 2
`define PPCD_PD_MISO 2
`define PPCD_PD_MOSI 3
`define PPCD_PD_SCK 4
`define PPCD_PD_SLAVE_SEL 5
`define PPCD_PD_ADDR_STROBE 6
`define PPCD_PD_RNW 7

// readable mask of the parallel io control register
`define PPCD_PARALLEL_IO_CONTROL_MASK 8'h20

`endif

// >>> verilog/ppcd_pkg.sv
package ppcd_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_EXPANDED,
    MODE_BOOT,
    MODE_TEST
  } ppcd_mode_e;

  typedef enum logic [2:0] {
    REG_PAR_CTRL,
    REG_PC_DATA,
    REG_PC_DIR,
    REG_PD_DATA,
    REG_PD_DIR,
    REG_PA_CTRL,
    REG_NONE
  } ppcd_reg_e;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } ppcd_bus_e;

endpackage

// >>> verilog/ppcd_sync.sv
`timescale 1ns/100ps
module ppcd_sync import ppcd_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] nxt_lvl;

  initial begin
    if (W < 1) begin
      $error("ppcd_sync width must be at least one");
    end
  end

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign nxt_lvl = (s2_ff & ~(s2_ff ^ s3_ff)) | (lvl_ff & (s2_ff ^ s3_ff));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_ff <= '0;
    end else begin
      lvl_ff <= nxt_lvl;
    end
  end

  assign level_out = lvl_ff;

endmodule

// >>> verilog/ppcd_io.sv
// Behaviour
// RULE_01 - single-chip: port C is gpio; expanded: muxed low address and data
// RULE_02 - expanded data phase: port C direction follows bus read/write
// RULE_03 - after reset port C inputs in single/boot, bus pins in expanded/test
// RULE_04 - port C direction bit 0 input, 1 output; resets to zero
// RULE_05 - port D read: inputs give pin level, outputs give driver input
// RULE_06 - port D writes go to a latch, driven only as gpio output
// RULE_07 - port D direction 0 input, 1 output; direction and latch reset zero
// RULE_08 - expanded/test: port D bits 6 and 7 drive strobe and read/write
// RULE_09 - spi enabled: bit 5 is slave select; slave ignores its direction bit
// RULE_10 - spi master: bit 5 input when direction 0, gpio output when 1
// RULE_11 - spi inputs on bits 2 to 4 are inputs regardless of direction
// RULE_12 - spi outputs on bits 2 to 4 drive only with direction bit set
// RULE_13 - port A bit 3 direction bit; output compare overrides it
// RULE_14 - capture/compare select: 0 compare five, 1 capture four; resets zero
// RULE_15 - parallel io control: only wired-or bit works, rest read zero
// RULE_16 - wired-or bit 1 makes port C open drain, 0 push-pull
// RULE_17 - open drain drives low only, releases pin when latch holds one
// RULE_18 - registers read/write on the bus, writes visible next cycle
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "ppcd_params.svh"
module ppcd_io import ppcd_pkg::*; #(
  parameter int PORT_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [1:0] MODE,
  input wire logic EXP_ADDR_PHASE,
  input wire logic EXP_RNW,
  input wire logic EXP_ADDR_STROBE,
  input wire logic [7:0] EXP_ADDR_LO,
  input wire logic [7:0] EXP_WDATA,
  output logic [7:0] EXP_RDATA,
  input wire logic SPI_EN,
  input wire logic SPI_MASTER,
  input wire logic SPI_MISO_OUT,
  input wire logic SPI_MOSI_OUT,
  input wire logic SPI_SCK_OUT,
  output logic [7:0] PD_SENSE,
  input wire logic [7:0] PC_IN,
  output logic [7:0] PC_OUT,
  output logic [7:0] PC_OE_N,
  input wire logic [7:0] PD_IN,
  output logic [7:0] PD_OUT,
  output logic [7:0] PD_OE_N,
  input wire logic PA3_IN,
  output logic PA3_OUT,
  output logic PA3_OE_N,
  output logic PA3_SENSE,
  input wire logic PA3_DATA,
  input wire logic OC_PA3_EN,
  input wire logic OC_PA3_LVL,
  output logic CAPTURE4_SEL,
  output logic [7:0] PULSE_ACCUM_CTRL
);

  initial begin
    if (PORT_W != 8) begin
      $error("ppcd_io serves eight-bit ports only");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  function automatic ppcd_reg_e decode_reg(input logic [7:0] addr);
    ppcd_reg_e r;
    case (addr[7:2])
      `PPCD_IDX_PAR_CTRL: r = REG_PAR_CTRL;
      `PPCD_IDX_PC_DATA: r = REG_PC_DATA;
      `PPCD_IDX_PC_DIR: r = REG_PC_DIR;
      `PPCD_IDX_PD_DATA: r = REG_PD_DATA;
      `PPCD_IDX_PD_DIR: r = REG_PD_DIR;
      `PPCD_IDX_PA_CTRL: r = REG_PA_CTRL;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction

  ppcd_bus_e bus_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [7:0] parallel_io_control_ff;
  logic [7:0] pc_lat_ff;
  logic [7:0] pc_dir_ff;
  logic [7:0] pd_lat_ff;
  logic [7:0] pd_dir_ff;
  logic [7:0] pulse_accum_control_ff;
  logic [7:0] pc_out_ff;
  logic [7:0] pc_oe_n_ff;
  logic [7:0] pd_out_ff;
  logic [7:0] pd_oe_n_ff;
  logic pa3_out_ff;
  logic pa3_oe_n_ff;
  logic [7:0] nxt_pc_out;
  logic [7:0] nxt_pc_oe_n;
  logic [7:0] nxt_pd_out;
  logic [7:0] nxt_pd_oe_n;
  logic [7:0] nxt_rd;
  logic [16:0] sense;
  logic [7:0] pc_sense;
  logic [7:0] pd_sense;
  logic wr_en;
  logic expanded;
  ppcd_reg_e req_reg;

  assign expanded = (ppcd_mode_e'(MODE) == MODE_EXPANDED) || (ppcd_mode_e'(MODE) == MODE_TEST);
  assign req_reg = decode_reg(AVS_ADDRESS);
  // write lands at the edge where the master sees waitrequest low
  assign wr_en = (bus_ff == BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0]; // RULE_18

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  ppcd_sync #(.W(17)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in({PA3_IN, PD_IN, PC_IN}),
    .level_out(sense)
  );

  assign pc_sense = sense[7:0];
  assign pd_sense = sense[15:8];
  assign EXP_RDATA = pc_sense;
  assign PD_SENSE = pd_sense;
  assign PA3_SENSE = sense[16];

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then one answer cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bus_ff <= BUS_IDLE;
      wait_ff <= 1'b1;
    end else begin
      case (bus_ff)
        BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_ff <= BUS_ACK;
            wait_ff <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_ff <= BUS_IDLE;
          wait_ff <= 1'b1;
        end
        default: begin
          bus_ff <= BUS_IDLE;
          wait_ff <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    nxt_rd = 8'h00;
    case (req_reg)
      REG_PAR_CTRL: nxt_rd = parallel_io_control_ff & `PPCD_PARALLEL_IO_CONTROL_MASK; // RULE_15
      REG_PC_DATA: nxt_rd = (pc_sense & ~pc_dir_ff) | (pc_lat_ff & pc_dir_ff);
      REG_PC_DIR: nxt_rd = pc_dir_ff;
      // driven bits read back the driver input, others the pin
      REG_PD_DATA: nxt_rd = (pd_sense & pd_oe_n_ff) | (pd_out_ff & ~pd_oe_n_ff); // RULE_05
      REG_PD_DIR: nxt_rd = pd_dir_ff;
      REG_PA_CTRL: nxt_rd = pulse_accum_control_ff;
      default: nxt_rd = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_ff <= 32'h0000_0000;
    end else if (bus_ff == BUS_IDLE && AVS_READ) begin
      rdata_ff <= {24'h00_0000, nxt_rd}; // RULE_18
    end
  end

  assign AVS_READDATA = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      parallel_io_control_ff <= `PPCD_RST_PAR_CTRL; // RULE_15
    end else if (wr_en && req_reg == REG_PAR_CTRL) begin
      parallel_io_control_ff <= AVS_WRITEDATA[7:0] & `PPCD_PARALLEL_IO_CONTROL_MASK; // RULE_15
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pc_lat_ff <= `PPCD_RST_PC_DATA;
      pc_dir_ff <= `PPCD_RST_PC_DIR; // RULE_04
    end else if (wr_en) begin
      if (req_reg == REG_PC_DATA) begin
        pc_lat_ff <= AVS_WRITEDATA[7:0];
      end
      if (req_reg == REG_PC_DIR) begin
        pc_dir_ff <= AVS_WRITEDATA[7:0]; // RULE_04
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pd_lat_ff <= `PPCD_RST_PD_DATA; // RULE_07
      pd_dir_ff <= `PPCD_RST_PD_DIR; // RULE_07
    end else if (wr_en) begin
      if (req_reg == REG_PD_DATA) begin
        pd_lat_ff <= AVS_WRITEDATA[7:0]; // RULE_06
      end
      if (req_reg == REG_PD_DIR) begin
        pd_dir_ff <= AVS_WRITEDATA[7:0];
      end
    end
  end

  // other pulse accumulator bits are only held for the timer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pulse_accum_control_ff <= `PPCD_RST_PA_CTRL; // RULE_14
    end else if (wr_en && req_reg == REG_PA_CTRL) begin
      pulse_accum_control_ff <= AVS_WRITEDATA[7:0];
    end
  end

  assign CAPTURE4_SEL = pulse_accum_control_ff[`PPCD_PULSE_ACCUM_CONTROL_CAP4_SEL]; // RULE_14
  assign PULSE_ACCUM_CTRL = pulse_accum_control_ff;

  ////////////////////////////////////////////////////////////////////////////
  // port C pins
  always_comb begin
    nxt_pc_out = pc_lat_ff; // RULE_01
    nxt_pc_oe_n = ~pc_dir_ff; // RULE_04
    if (expanded) begin
      if (EXP_ADDR_PHASE) begin
        nxt_pc_out = EXP_ADDR_LO; // RULE_01
        nxt_pc_oe_n = 8'h00;
      end else begin
        nxt_pc_out = EXP_WDATA;
        nxt_pc_oe_n = {8{EXP_RNW}}; // RULE_02
      end
    end else if (parallel_io_control_ff[`PPCD_PARALLEL_IO_CONTROL_OPEN_DRAIN]) begin
      // low only; a latched one lets the pull-up win
      nxt_pc_out = 8'h00; // RULE_17
      nxt_pc_oe_n = ~(pc_dir_ff & ~pc_lat_ff); // RULE_16
    end
  end

  // reset leaves inputs; mode takes over from the first edge after release
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pc_out_ff <= 8'h00;
      pc_oe_n_ff <= 8'hff; // RULE_03
    end else begin
      pc_out_ff <= nxt_pc_out;
      pc_oe_n_ff <= nxt_pc_oe_n; // RULE_03
    end
  end

  assign PC_OUT = pc_out_ff;
  assign PC_OE_N = pc_oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // port D pins
  always_comb begin
    nxt_pd_out = pd_lat_ff; // RULE_06
    nxt_pd_oe_n = ~pd_dir_ff; // RULE_07
    if (SPI_EN) begin
      if (SPI_MASTER) begin
        // bit 5 stays on its direction bit: fault input or gpio output
        nxt_pd_oe_n[`PPCD_PD_MISO] = 1'b1; // RULE_11
        nxt_pd_out[`PPCD_PD_MOSI] = SPI_MOSI_OUT; // RULE_12
        nxt_pd_out[`PPCD_PD_SCK] = SPI_SCK_OUT; // RULE_12
        nxt_pd_oe_n[`PPCD_PD_SLAVE_SEL] = ~pd_dir_ff[`PPCD_PD_SLAVE_SEL]; // RULE_10
      end else begin
        nxt_pd_oe_n[`PPCD_PD_SLAVE_SEL] = 1'b1; // RULE_09
        nxt_pd_oe_n[`PPCD_PD_MOSI] = 1'b1; // RULE_11
        nxt_pd_oe_n[`PPCD_PD_SCK] = 1'b1; // RULE_11
        nxt_pd_out[`PPCD_PD_MISO] = SPI_MISO_OUT; // RULE_12
      end
    end
    if (expanded) begin
      nxt_pd_out[`PPCD_PD_ADDR_STROBE] = EXP_ADDR_STROBE; // RULE_08
      nxt_pd_out[`PPCD_PD_RNW] = EXP_RNW; // RULE_08
      nxt_pd_oe_n[`PPCD_PD_ADDR_STROBE] = 1'b0;
      nxt_pd_oe_n[`PPCD_PD_RNW] = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pd_out_ff <= 8'h00;
      pd_oe_n_ff <= 8'hff;
    end else begin
      pd_out_ff <= nxt_pd_out;
      pd_oe_n_ff <= nxt_pd_oe_n;
    end
  end

  assign PD_OUT = pd_out_ff;
  assign PD_OE_N = pd_oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // port A bit 3
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pa3_out_ff <= 1'b0;
      pa3_oe_n_ff <= 1'b1;
    end else if (OC_PA3_EN) begin
      pa3_out_ff <= OC_PA3_LVL; // RULE_13
      pa3_oe_n_ff <= 1'b0;
    end else begin
      pa3_out_ff <= PA3_DATA;
      pa3_oe_n_ff <= ~pulse_accum_control_ff[`PPCD_PULSE_ACCUM_CONTROL_PA3_DIR]; // RULE_13
    end
  end

  assign PA3_OUT = pa3_out_ff;
  assign PA3_OE_N = pa3_oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  pc_exp_addr_a: assert property ( // RULE_01
    RST_N && expanded && EXP_ADDR_PHASE |=> PC_OE_N == 8'h00 && PC_OUT == $past(EXP_ADDR_LO))
    else $error("port C did not drive the low address");

  pc_data_dir_a: assert property ( // RULE_02
    RST_N && expanded && !EXP_ADDR_PHASE |=> PC_OE_N == {8{$past(EXP_RNW)}})
    else $error("port C data direction does not follow read/write");

  pc_open_drain_a: assert property ( // RULE_17
    !expanded && parallel_io_control_ff[`PPCD_PARALLEL_IO_CONTROL_OPEN_DRAIN]
    |=> PC_OUT == 8'h00 && PC_OE_N == ~($past(pc_dir_ff) & ~$past(pc_lat_ff)))
    else $error("port C open drain drive wrong");

  pd_strobe_pins_a: assert property ( // RULE_08
    RST_N && expanded |=> PD_OE_N[7:6] == 2'b00 && PD_OUT[6] == $past(EXP_ADDR_STROBE)
    && PD_OUT[7] == $past(EXP_RNW))
    else $error("port D strobe pins not driven");

  spi_slave_in_a: assert property ( // RULE_09
    RST_N && SPI_EN && !SPI_MASTER |=> PD_OE_N[5:3] == 3'b111)
    else $error("slave spi inputs were driven");

  spi_master_io_a: assert property ( // RULE_12
    RST_N && SPI_EN && SPI_MASTER |=> PD_OE_N[2] && PD_OE_N[3] == !$past(pd_dir_ff[3]))
    else $error("master spi pin direction wrong");

  pa3_override_a: assert property ( // RULE_13
    RST_N && OC_PA3_EN |=> !PA3_OE_N && PA3_OUT == $past(OC_PA3_LVL))
    else $error("compare did not take over port A bit 3");

  bus_answer_a: assert property ( // RULE_18
    (AVS_READ || AVS_WRITE) && bus_ff == BUS_IDLE |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle after request");

  dir_write_a: assert property ( // RULE_04
    wr_en && req_reg == REG_PC_DIR |=> pc_dir_ff == $past(AVS_WRITEDATA[7:0]))
    else $error("port C direction write lost");

  parallel_io_control_read_a: assert property ( // RULE_15
    bus_ff == BUS_ACK && AVS_READ |-> (AVS_READDATA & 32'hffff_ffdf) == 32'h0000_0000
    || decode_reg(AVS_ADDRESS) != REG_PAR_CTRL)
    else $error("parallel io control reads unused bits");

  pd_reset_a: assert property (disable iff (1'b0) // RULE_07
    !RST_N |=> pd_dir_ff == 8'h00 && pd_lat_ff == 8'h00 && PD_OE_N == 8'hff)
    else $error("port D did not reset");

  exp_read_c: cover property (expanded && !EXP_ADDR_PHASE && EXP_RNW);
  spi_master_c: cover property (SPI_EN && SPI_MASTER && pd_dir_ff[4]);
  open_drain_c: cover property (!expanded && parallel_io_control_ff[5] && pc_dir_ff != 8'h00);
  bus_write_c: cover property (wr_en && req_reg == REG_PD_DATA);

endmodule

// >>> tb/ppcd_pin_model.sv
`timescale 1ns/100ps
module ppcd_pin_model (
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe_n,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe_n,
  input wire logic pa3_out,
  input wire logic pa3_oe_n,
  input wire logic [7:0] ext_pc,
  input wire logic [7:0] ext_pd,
  input wire logic ext_pa3,
  output logic [7:0] pc_pin,
  output logic [7:0] pd_pin,
  output logic pa3_pin
);
  // far side always drives released pins, so no level is left floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pc_pin[i] = pc_oe_n[i] ? ext_pc[i] : pc_out[i];
      pd_pin[i] = pd_oe_n[i] ? ext_pd[i] : pd_out[i];
    end
    pa3_pin = pa3_oe_n ? ext_pa3 : pa3_out;
  end
endmodule

// >>> tb/parallel_port_c_d_io_tb_top.sv
`timescale 1ns/100ps
`include "ppcd_params.svh"
module parallel_port_c_d_io_tb_top import ppcd_pkg::*;;
  logic clk, rst_n, rd, wr, waitreq, ap, rnw, strb, spi_en, spi_m, miso, mosi, sck;
  logic pa3_in, pa3_out, pa3_oe_n, pa3_sense, pa3_data, oc_en, oc_lvl, cap4, ext_pa3;
  logic [7:0] addr, exp_addr, exp_wd, exp_rd, pd_sense, pc_in, pc_out, pc_oe_n;
  logic [7:0] pd_in, pd_out, pd_oe_n, pulse_accum_control, ext_pc, ext_pd, rv;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [1:0] mode;
  int errors = 0;
  int cmp_count = 0;
  ppcd_io u_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .MODE(mode), .EXP_ADDR_PHASE(ap), .EXP_RNW(rnw),
    .EXP_ADDR_STROBE(strb), .EXP_ADDR_LO(exp_addr), .EXP_WDATA(exp_wd),
    .EXP_RDATA(exp_rd), .SPI_EN(spi_en), .SPI_MASTER(spi_m), .SPI_MISO_OUT(miso),
    .SPI_MOSI_OUT(mosi), .SPI_SCK_OUT(sck), .PD_SENSE(pd_sense), .PC_IN(pc_in),
    .PC_OUT(pc_out), .PC_OE_N(pc_oe_n), .PD_IN(pd_in), .PD_OUT(pd_out),
    .PD_OE_N(pd_oe_n), .PA3_IN(pa3_in), .PA3_OUT(pa3_out), .PA3_OE_N(pa3_oe_n),
    .PA3_SENSE(pa3_sense), .PA3_DATA(pa3_data), .OC_PA3_EN(oc_en), .OC_PA3_LVL(oc_lvl),
    .CAPTURE4_SEL(cap4), .PULSE_ACCUM_CTRL(pulse_accum_control));
  ppcd_pin_model u_pins (.pc_out(pc_out), .pc_oe_n(pc_oe_n), .pd_out(pd_out),
    .pd_oe_n(pd_oe_n), .pa3_out(pa3_out), .pa3_oe_n(pa3_oe_n), .ext_pc(ext_pc),
    .ext_pd(ext_pd), .ext_pa3(ext_pa3), .pc_pin(pc_in), .pd_pin(pd_in), .pa3_pin(pa3_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // master holds the request until it samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                     input logic [3:0] ben);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    be <= ben;
    wr <= w;
    rd <= ~w;
    // no cycle limit here; a hung slave is left to the watchdog
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rv = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp, input string msg);
    bus(1'b0, idx, 8'h00, 4'hf);
    chk(rv, exp, msg);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(`PPCD_IDX_PAR_CTRL, 8'h00, "ctrl rst");
    rchk(`PPCD_IDX_PC_DIR, 8'h00, "c dir rst");
    rchk(`PPCD_IDX_PD_DATA, 8'h00, "d data rst");
    rchk(`PPCD_IDX_PD_DIR, 8'h00, "d dir rst");
    rchk(`PPCD_IDX_PA_CTRL, 8'h00, "pulse_accum_control rst");
    chk(pc_oe_n, 8'hff, "c hiz rst");
    chk(pd_oe_n, 8'hff, "d hiz rst");
    bus(1'b1, 6'h3f, 8'h55, 4'hf);
    rchk(6'h3f, 8'h00, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_port_c;
    ext_pc <= 8'h3c;
    wreg(`PPCD_IDX_PC_DATA, 8'ha5);
    wreg(`PPCD_IDX_PC_DIR, 8'h0f);
    settle(6);
    chk(pc_oe_n, 8'hf0, "c dir");
    chk(pc_out & 8'h0f, 8'h05, "c out");
    rchk(`PPCD_IDX_PC_DATA, 8'h35, "c read");
    bus(1'b1, `PPCD_IDX_PAR_CTRL, 8'hff, 4'h0);
    rchk(`PPCD_IDX_PAR_CTRL, 8'h00, "be0 ignored");
    wreg(`PPCD_IDX_PAR_CTRL, 8'hff);
    rchk(`PPCD_IDX_PAR_CTRL, 8'h20, "ctrl mask");
    wreg(`PPCD_IDX_PC_DIR, 8'hff);
    settle(2);
    chk(pc_oe_n, 8'ha5, "od release");
    chk(pc_out & ~pc_oe_n, 8'h00, "od low only");
    wreg(`PPCD_IDX_PAR_CTRL, 8'h00);
    settle(2);
    chk(pc_oe_n, 8'h00, "push pull");
    chk(pc_out, 8'ha5, "push pull out");
    wreg(`PPCD_IDX_PC_DIR, 8'h00);
    $display("test port_c done");
  endtask
  task automatic t_port_d;
    ext_pd <= 8'ha3;
    wreg(`PPCD_IDX_PD_DATA, 8'h3c);
    settle(2);
    chk(pd_oe_n, 8'hff, "latch only");
    wreg(`PPCD_IDX_PD_DIR, 8'h0f);
    settle(6);
    chk(pd_oe_n, 8'hf0, "d dir");
    chk(pd_out & 8'h0f, 8'h0c, "d out");
    chk(pd_sense, 8'hac, "d sense");
    rchk(`PPCD_IDX_PD_DATA, 8'hac, "d read");
    wreg(`PPCD_IDX_PD_DIR, 8'h00);
    $display("test port_d done");
  endtask
  task automatic t_expanded;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mode <= m[1:0];
      ap <= 1'b1;
      exp_addr <= 8'h5a;
      strb <= 1'b1;
      rnw <= 1'b0;
      settle(3);
      if (m[0]) begin
        chk(pc_oe_n, 8'h00, "addr drive");
        chk(pc_out, 8'h5a, "addr lo");
        chk(pd_oe_n & 8'hc0, 8'h00, "d67 drive");
        chk(pd_out & 8'hc0, 8'h40, "strobe rnw");
      end else begin
        chk(pc_oe_n, 8'hff, "gpio hiz");
      end
    end
    @(posedge clk);
    mode <= MODE_EXPANDED;
    ap <= 1'b0;
    exp_wd <= 8'hc3;
    settle(3);
    chk(pc_out, 8'hc3, "write data");
    @(posedge clk);
    rnw <= 1'b1;
    strb <= 1'b0;
    ext_pc <= 8'h96;
    settle(7);
    chk(pc_oe_n, 8'hff, "read release");
    chk(exp_rd, 8'h96, "read data");
    chk(pd_out & 8'hc0, 8'h80, "rnw level");
    @(posedge clk);
    mode <= MODE_SINGLE;
    $display("test expanded done");
  endtask
  task automatic t_spi;
    @(posedge clk);
    spi_en <= 1'b1;
    spi_m <= 1'b1;
    settle(3);
    chk(pd_oe_n & 8'h3c, 8'h3c, "master no dir");
    wreg(`PPCD_IDX_PD_DATA, 8'h20);
    wreg(`PPCD_IDX_PD_DIR, 8'h3c);
    settle(2);
    chk(pd_oe_n & 8'h3c, 8'h04, "master dir");
    chk(pd_out & 8'h38, 8'h38, "master out");
    rchk(`PPCD_IDX_PD_DATA, 8'hbb, "driver read");
    @(posedge clk);
    spi_m <= 1'b0;
    settle(3);
    chk(pd_oe_n & 8'h3c, 8'h38, "slave dir");
    chk(pd_out & 8'h04, 8'h04, "slave miso");
    wreg(`PPCD_IDX_PD_DIR, 8'h00);
    @(posedge clk);
    spi_en <= 1'b0;
    $display("test spi done");
  endtask
  task automatic t_pa3;
    wreg(`PPCD_IDX_PA_CTRL, 8'h0c);
    settle(2);
    rchk(`PPCD_IDX_PA_CTRL, 8'h0c, "pulse_accum_control rw");
    chk(pulse_accum_control, 8'h0c, "pulse_accum_control port");
    chk(cap4, 1'b1, "cap4 sel");
    chk(pa3_oe_n, 1'b0, "pa3 out");
    chk(pa3_out, 1'b1, "pa3 data");
    @(posedge clk);
    oc_en <= 1'b1;
    settle(3);
    chk(pa3_out, 1'b0, "oc override");
    @(posedge clk);
    oc_en <= 1'b0;
    wreg(`PPCD_IDX_PA_CTRL, 8'h00);
    settle(7);
    chk(cap4, 1'b0, "oc5 sel");
    chk(pa3_oe_n, 1'b1, "pa3 in");
    chk(pa3_sense, 1'b1, "pa3 sense");
    $display("test pa3 done");
  endtask
  // mode pins stay put across reset, so bus pins must come back by themselves
  task automatic t_mid_reset;
    wreg(`PPCD_IDX_PC_DIR, 8'hff);
    wreg(`PPCD_IDX_PAR_CTRL, 8'hff);
    @(posedge clk);
    mode <= MODE_EXPANDED;
    ap <= 1'b1;
    exp_addr <= 8'ha5;
    rst_n <= 1'b0;
    settle(2);
    chk(pc_oe_n, 8'hff, "reset hiz");
    rst_n <= 1'b1;
    settle(3);
    chk(pc_oe_n, 8'h00, "reset bus pins");
    chk(pc_out, 8'ha5, "reset addr");
    rchk(`PPCD_IDX_PC_DIR, 8'h00, "c dir cleared");
    rchk(`PPCD_IDX_PAR_CTRL, 8'h00, "ctrl cleared");
    @(posedge clk);
    mode <= MODE_SINGLE;
    $display("test mid_reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // whole run needs a few hundred cycles; twenty thousand is ample
  initial begin
    #2000000;
    errors++;
    $display("[FAIL] %0t watchdog", $time);
    summarize();
  end
  initial begin
    {rst_n, rd, wr, ap, rnw, strb, spi_en, spi_m, oc_en, oc_lvl} = '0;
    {miso, mosi, sck, pa3_data, ext_pa3} = 5'h1f;
    {addr, exp_addr, exp_wd, ext_pc, ext_pd} = '0;
    wdata = '0;
    be = 4'hf;
    mode = MODE_SINGLE;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_port_c();
    t_port_d();
    t_expanded();
    t_spi();
    t_pa3();
    t_mid_reset();
    summarize();
  end
endmodule
